// file: src/sevg_event_vectors.sv
`timescale 1ns/1ns
`include "sevg_consts.svh"

// Behaviour
// - Reset codes 02h brownout, 04h pin, 06h software brownout.
// - Code 0Eh high supply event; 0Ch,10h,12h reserved.
// - Code 14h software power-on, power-on class.
// - Code 16h watchdog expiry, power-up-clear class.
// - Codes 18h watchdog key, 1Ah memctl key, power-up-clear.
// - Code 1Ch uncorrectable memory error, power-up-clear.
// - Power, protection, clock key violations cause power-up-clear.
// - Code 26h protected segment violation; 28h reserved.
// - Codes 2Ah,2Ch,2Eh segment one to three violations.
// - System vector 04h uncorrectable, 06h access time; 02h reserved.
// - System vector 08h, 0Ch, 0Eh segments; 0Ah reserved.
// - System vector 12h vacant, 14h/16h mailbox events.
// - System vector 18h correctable; 1Eh accelerator fault lowest.
// - User vector 02h unnamed, 04h oscillator, 06h RAM conflict; rest reserved.
// - Debug mailbox with input and output flags.
// - Code 00h idle; lower code wins.
// - Enable bits block non-maskable events; global enable cannot.
// - Peripheral area fetch raises a reset.

module sevg_event_vectors (
    input  wire logic                   core_clk_i,
    input  wire logic                   reset_n_i,
    input  wire sevg_pkg::sevg_addr_t   bus_addr_i,
    input  wire sevg_pkg::sevg_word_t   bus_wdata_i,
    input  wire logic                   bus_wr_i,
    input  wire logic                   bus_rd_i,
    output sevg_pkg::sevg_word_t        bus_rdata_o,
    input  wire logic [23:0]            rst_cause_set_i,
    input  wire logic [15:0]            sys_cause_set_i,
    input  wire logic [15:0]            user_cause_set_i,
    input  wire logic                   dbg_wr_i,
    input  wire sevg_pkg::sevg_word_t   dbg_wdata_i,
    input  wire logic                   dbg_take_i,
    output sevg_pkg::sevg_word_t        dbg_rdata_o,
    output logic                        dbg_in_full_o,
    output logic                        dbg_out_full_o,
    output logic                        sys_nmi_req_o,
    output logic                        user_nmi_req_o,
    output logic                        brownout_reset_o,
    output logic                        por_reset_o,
    output logic                        clear_reset_o
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [23:0]          rst_flags_r;
    logic [23:0]          rst_flags_nxt;
    logic [15:0]          sys_flags_r;
    logic [15:0]          sys_flags_nxt;
    logic [15:0]          user_flags_r;
    logic [15:0]          user_flags_nxt;
    sevg_pkg::sevg_word_t sys_en_r;
    sevg_pkg::sevg_word_t user_en_r;
    sevg_pkg::sevg_word_t rst_code;
    sevg_pkg::sevg_word_t sys_code;
    sevg_pkg::sevg_word_t user_code;
    logic [23:0]          rst_sel;
    logic [15:0]          sys_sel;
    logic [15:0]          user_sel;
    logic [23:0]          rst_set;
    logic [15:0]          sys_set;
    logic [15:0]          user_set;
    logic                 rd_rst;
    logic                 rd_sys;
    logic                 rd_user;
    logic                 rd_mbox_in;
    logic                 wr_mbox_out;
    logic                 mbox_in_evt;
    logic                 mbox_out_evt;
    sevg_pkg::sevg_word_t mbox_in_data;
    sevg_pkg::sevg_word_t rdata_nxt;
    sevg_pkg::sevg_class_t cause_class;

    assign rd_rst      = bus_rd_i && bus_addr_i == `SEVG_ADDR_RST_VEC;
    assign rd_sys      = bus_rd_i && bus_addr_i == `SEVG_ADDR_SYS_VEC;
    assign rd_user     = bus_rd_i && bus_addr_i == `SEVG_ADDR_USER_VEC;
    assign rd_mbox_in  = bus_rd_i && bus_addr_i == `SEVG_ADDR_MBOX_IN;
    assign wr_mbox_out = bus_wr_i && bus_addr_i == `SEVG_ADDR_MBOX_OUT;

    // ****************************************************************
    // Cause capture
    // ****************************************************************
    // Reserved positions are masked so that no reserved code can ever be reported.
    assign rst_set  = rst_cause_set_i & `SEVG_RST_VALID;
    always_comb begin
        sys_set = sys_cause_set_i;
        sys_set[`SEVG_SYS_MBOX_IN]  = mbox_in_evt;
        sys_set[`SEVG_SYS_MBOX_OUT] = mbox_out_evt;
        sys_set = sys_set & `SEVG_SYS_VALID;
    end
    assign user_set = user_cause_set_i & `SEVG_USER_VALID;

    // A cause arriving in the cycle its flag is read keeps the flag set.
    assign rst_flags_nxt  = (rst_flags_r & ~(rd_rst ? rst_sel : '0)) | rst_set;
    assign sys_flags_nxt  = (sys_flags_r & ~(rd_sys ? sys_sel : '0)) | sys_set;
    assign user_flags_nxt = (user_flags_r & ~(rd_user ? user_sel : '0)) | user_set;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_flags_r <= '0;
        end else begin
            rst_flags_r <= rst_flags_nxt;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sys_flags_r  <= '0;
            user_flags_r <= '0;
        end else begin
            sys_flags_r  <= sys_flags_nxt;
            user_flags_r <= user_flags_nxt;
        end
    end

    // ****************************************************************
    // Enable registers
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sys_en_r  <= `SEVG_EN_RESET;
            user_en_r <= `SEVG_EN_RESET;
        end else if (bus_wr_i && bus_addr_i == `SEVG_ADDR_SYS_EN) begin
            sys_en_r  <= bus_wdata_i;
        end else if (bus_wr_i && bus_addr_i == `SEVG_ADDR_USER_EN) begin
            user_en_r <= bus_wdata_i;
        end
    end

    // ****************************************************************
    // Priority encoders
    // ****************************************************************
    sevg_prio_enc #(.N(`SEVG_RST_N)) u_rst_enc (
        .pending_i (rst_flags_r),
        .code_o    (rst_code),
        .sel_o     (rst_sel)
    );

    // Disabled causes stay latched but neither report nor request; there is no
    // global enable input, so nothing else can hold them back.
    sevg_prio_enc #(.N(`SEVG_NMI_N)) u_sys_enc (
        .pending_i (sys_flags_r & sys_en_r),
        .code_o    (sys_code),
        .sel_o     (sys_sel)
    );

    sevg_prio_enc #(.N(`SEVG_NMI_N)) u_user_enc (
        .pending_i (user_flags_r & user_en_r),
        .code_o    (user_code),
        .sel_o     (user_sel)
    );

    // ****************************************************************
    // Mailbox
    // ****************************************************************
    sevg_mailbox u_mailbox (
        .core_clk_i   (core_clk_i),
        .reset_n_i    (reset_n_i),
        .dbg_wr_i     (dbg_wr_i),
        .dbg_wdata_i  (dbg_wdata_i),
        .dbg_take_i   (dbg_take_i),
        .app_in_rd_i  (rd_mbox_in),
        .app_out_wr_i (wr_mbox_out),
        .app_wdata_i  (bus_wdata_i),
        .in_data_o    (mbox_in_data),
        .out_data_o   (dbg_rdata_o),
        .in_full_o    (dbg_in_full_o),
        .out_full_o   (dbg_out_full_o),
        .in_evt_o     (mbox_in_evt),
        .out_evt_o    (mbox_out_evt)
    );

    // ****************************************************************
    // Register read
    // ****************************************************************
    always_comb begin
        rdata_nxt = `SEVG_ZERO16;
        if (rd_rst) begin
            rdata_nxt = rst_code;
        end else if (rd_sys) begin
            rdata_nxt = sys_code;
        end else if (rd_user) begin
            rdata_nxt = user_code;
        end else if (bus_rd_i && bus_addr_i == `SEVG_ADDR_SYS_EN) begin
            rdata_nxt = sys_en_r;
        end else if (bus_rd_i && bus_addr_i == `SEVG_ADDR_USER_EN) begin
            rdata_nxt = user_en_r;
        end else if (bus_rd_i && bus_addr_i == `SEVG_ADDR_MBOX_CTL) begin
            rdata_nxt = {14'h0000, dbg_out_full_o, dbg_in_full_o};
        end else if (rd_mbox_in) begin
            rdata_nxt = mbox_in_data;
        end else if (bus_rd_i && bus_addr_i == `SEVG_ADDR_MBOX_OUT) begin
            rdata_nxt = dbg_rdata_o;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_rdata_o <= `SEVG_ZERO16;
        end else begin
            bus_rdata_o <= rdata_nxt;
        end
    end

    // ****************************************************************
    // Reset class and request outputs
    // ****************************************************************
    // The strongest class wins when causes of several classes arrive together.
    always_comb begin
        cause_class = sevg_pkg::SEVG_CLASS_NONE;
        if (|(rst_set & `SEVG_RST_BROWN_MASK)) begin
            cause_class = sevg_pkg::SEVG_CLASS_BROWN;
        end else if (|(rst_set & `SEVG_RST_POR_MASK)) begin
            cause_class = sevg_pkg::SEVG_CLASS_POR;
        end else if (|(rst_set & `SEVG_RST_CLEAR_MASK)) begin
            cause_class = sevg_pkg::SEVG_CLASS_CLEAR;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            brownout_reset_o <= 1'b0;
            por_reset_o      <= 1'b0;
            clear_reset_o    <= 1'b0;
        end else begin
            brownout_reset_o <= cause_class == sevg_pkg::SEVG_CLASS_BROWN;
            por_reset_o      <= cause_class == sevg_pkg::SEVG_CLASS_POR;
            clear_reset_o    <= cause_class == sevg_pkg::SEVG_CLASS_CLEAR;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sys_nmi_req_o  <= 1'b0;
            user_nmi_req_o <= 1'b0;
        end else begin
            sys_nmi_req_o  <= |(sys_flags_nxt & sys_en_r);
            user_nmi_req_o <= |(user_flags_nxt & user_en_r);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    prio_lowest_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        rst_code != `SEVG_ZERO16 |->
            (rst_flags_r & ((24'h000001 << rst_code[5:1]) - 24'h000001)) == '0
            && rst_flags_r[rst_code[5:1]])
        else $error("reset vector does not report lowest pending cause");
    idle_zero_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        rst_flags_r == '0 |-> rst_code == `SEVG_ZERO16)
        else $error("reset vector nonzero with nothing pending");
    read_clear_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        rd_rst && rst_code != `SEVG_ZERO16 && !rst_cause_set_i[rst_code[5:1]]
        |=> bus_rdata_o == $past(rst_code) && !rst_flags_r[$past(rst_code[5:1])])
        else $error("reset vector read did not return and clear top cause");
    set_wins_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        rd_sys && (sys_sel & sys_set) != '0 |=> (sys_flags_r & $past(sys_sel)) != '0)
        else $error("cause lost when set and read in the same cycle");
    reserved_never_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (rst_flags_r & ~`SEVG_RST_VALID) == '0 && (user_flags_r & ~`SEVG_USER_VALID) == '0)
        else $error("reserved cause position became pending");
    brownout_code_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        rst_cause_set_i[`SEVG_RST_BROWNOUT] ##1 rst_code == 16'h0002 |-> brownout_reset_o)
        else $error("brownout cause without brownout class reset");
    wdog_clear_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        rst_cause_set_i[`SEVG_RST_WDOG] && (rst_cause_set_i & 24'h0007fe) == '0
        |=> clear_reset_o && rst_flags_r[`SEVG_RST_WDOG])
        else $error("watchdog expiry did not raise power-up-clear");
    swpor_class_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        rst_cause_set_i[`SEVG_RST_SW_POR] && (rst_cause_set_i & `SEVG_RST_BROWN_MASK) == '0
        |=> por_reset_o && !clear_reset_o)
        else $error("software power-on request not classed as power-on");
    fetch_reset_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        rst_cause_set_i[`SEVG_RST_PERIPH_FETCH]
        |=> brownout_reset_o || por_reset_o || clear_reset_o)
        else $error("peripheral area fetch raised no reset");
    nmi_gate_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $past(sys_en_r) == `SEVG_ZERO16 && sys_en_r == `SEVG_ZERO16 |-> !sys_nmi_req_o)
        else $error("disabled system events still request");
    osc_code_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (user_flags_r & user_en_r) == 16'h0004 |-> user_code == 16'h0004)
        else $error("oscillator fault not reported as code 04h");
    mbox_evt_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        dbg_wr_i && sys_en_r[`SEVG_SYS_MBOX_IN] |-> ##2 sys_flags_r[`SEVG_SYS_MBOX_IN])
        else $error("mailbox input event not latched");
    sys_reserved_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (sys_flags_r & ~`SEVG_SYS_VALID) == '0)
        else $error("reserved system cause position became pending");
    sys_req_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        sys_nmi_req_o == |(sys_flags_r & $past(sys_en_r)))
        else $error("system request does not match enabled pending causes");
    rdata_idle_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !$past(bus_rd_i) |-> bus_rdata_o == `SEVG_ZERO16)
        else $error("read data present without a read");
    class_single_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $onehot0({brownout_reset_o, por_reset_o, clear_reset_o}))
        else $error("several reset classes raised at once");
endmodule

// file: common/sevg_consts.svh
`ifndef SEVG_CONSTS_SVH
`define SEVG_CONSTS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define SEVG_ADDR_USER_VEC     16'h019a
`define SEVG_ADDR_SYS_VEC      16'h019c
`define SEVG_ADDR_RST_VEC      16'h019e
`define SEVG_ADDR_SYS_EN       16'h0180
`define SEVG_ADDR_USER_EN      16'h0182
`define SEVG_ADDR_MBOX_CTL     16'h0184
`define SEVG_ADDR_MBOX_IN      16'h0186
`define SEVG_ADDR_MBOX_OUT     16'h0188

// ****************************************************************
// Cause counts, valid masks and reset values
// ****************************************************************
`define SEVG_RST_N             24
`define SEVG_NMI_N             16
`define SEVG_RST_VALID         24'heffcbe
`define SEVG_RST_BROWN_MASK    24'h0000be
`define SEVG_RST_POR_MASK      24'h000400
`define SEVG_RST_CLEAR_MASK    24'heff800
`define SEVG_SYS_VALID         16'hffdc
`define SEVG_USER_VALID        16'h000e
`define SEVG_EN_RESET          16'hffff
`define SEVG_ZERO16            16'h0000

// ****************************************************************
// Cause bit positions; the vector code is twice the position
// ****************************************************************
`define SEVG_RST_BROWNOUT      1
`define SEVG_RST_PIN           2
`define SEVG_RST_SW_BROWN      3
`define SEVG_RST_HIGH_SUPPLY   7
`define SEVG_RST_SW_POR        10
`define SEVG_RST_WDOG          11
`define SEVG_RST_WDOG_KEY      12
`define SEVG_RST_MEMCTL_KEY    13
`define SEVG_RST_UNCORR        14
`define SEVG_RST_PERIPH_FETCH  15
`define SEVG_RST_POWER_KEY     16
`define SEVG_RST_PROT_KEY      17
`define SEVG_RST_CLK_KEY       18
`define SEVG_RST_IP_SEG        19
`define SEVG_RST_SEG1          21
`define SEVG_RST_SEG3          23
`define SEVG_SYS_UNCORR        2
`define SEVG_SYS_ACC_TIME      3
`define SEVG_SYS_IP_SEG        4
`define SEVG_SYS_SEG1          6
`define SEVG_SYS_SEG2          7
`define SEVG_SYS_VACANT        9
`define SEVG_SYS_MBOX_IN       10
`define SEVG_SYS_MBOX_OUT      11
`define SEVG_SYS_CORR          12
`define SEVG_SYS_ACCEL_CMD     15
`define SEVG_USER_OSC          2
`define SEVG_USER_RAM_CONFLICT 3

`endif

// file: common/sevg_pkg.sv
package sevg_pkg;
    typedef logic [15:0] sevg_word_t;
    typedef logic [15:0] sevg_addr_t;
    typedef enum logic [1:0] {
        SEVG_CLASS_NONE,
        SEVG_CLASS_BROWN,
        SEVG_CLASS_POR,
        SEVG_CLASS_CLEAR
    } sevg_class_t;
endpackage

// file: src/sevg_prio_enc.sv
`timescale 1ns/1ns
`include "sevg_consts.svh"

// ****************************************************************
// Lowest pending position wins; code is twice the position.
// ****************************************************************
module sevg_prio_enc #(
    parameter int N = 16
) (
    input  wire logic [N-1:0]      pending_i,
    output sevg_pkg::sevg_word_t   code_o,
    output logic [N-1:0]           sel_o
);
    always_comb begin
        code_o = `SEVG_ZERO16;
        sel_o  = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pending_i[i]) begin
                code_o = 16'(2 * i);
                sel_o  = N'(1) << i;
            end
        end
    end
endmodule

// file: src/sevg_mailbox.sv
`timescale 1ns/1ns
`include "sevg_consts.svh"

// ****************************************************************
// Debug mailbox between the test port and the application.
// ****************************************************************
module sevg_mailbox (
    input  wire logic                 core_clk_i,
    input  wire logic                 reset_n_i,
    input  wire logic                 dbg_wr_i,
    input  wire sevg_pkg::sevg_word_t dbg_wdata_i,
    input  wire logic                 dbg_take_i,
    input  wire logic                 app_in_rd_i,
    input  wire logic                 app_out_wr_i,
    input  wire sevg_pkg::sevg_word_t app_wdata_i,
    output sevg_pkg::sevg_word_t      in_data_o,
    output sevg_pkg::sevg_word_t      out_data_o,
    output logic                      in_full_o,
    output logic                      out_full_o,
    output logic                      in_evt_o,
    output logic                      out_evt_o
);
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            in_data_o <= `SEVG_ZERO16;
        end else if (dbg_wr_i) begin
            in_data_o <= dbg_wdata_i;
        end
    end

    // A debugger write in the same cycle as the application read keeps the flag set.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            in_full_o <= 1'b0;
        end else if (dbg_wr_i) begin
            in_full_o <= 1'b1;
        end else if (app_in_rd_i) begin
            in_full_o <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_data_o <= `SEVG_ZERO16;
            out_full_o <= 1'b0;
        end else if (app_out_wr_i) begin
            out_data_o <= app_wdata_i;
            out_full_o <= 1'b1;
        end else if (dbg_take_i) begin
            out_full_o <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            in_evt_o  <= 1'b0;
            out_evt_o <= 1'b0;
        end else begin
            in_evt_o  <= dbg_wr_i;
            out_evt_o <= dbg_take_i && out_full_o;
        end
    end

    mbox_fill_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        dbg_wr_i |=> in_full_o && in_evt_o && in_data_o == $past(dbg_wdata_i))
        else $error("mailbox input not filled after debugger write");
    mbox_take_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        dbg_take_i && !app_out_wr_i |=> !out_full_o)
        else $error("mailbox output still full after debugger take");
endmodule

// file: bench/sevg_core_model.sv
`timescale 1ns/1ns

// ****************************************************************
// Core side of the register port: one access at a time, no waits.
// ****************************************************************
module sevg_core_model (
    input  wire logic                 core_clk_i,
    output sevg_pkg::sevg_addr_t      bus_addr_o,
    output sevg_pkg::sevg_word_t      bus_wdata_o,
    output logic                      bus_wr_o,
    output logic                      bus_rd_o,
    input  wire sevg_pkg::sevg_word_t bus_rdata_i
);
    initial begin
        bus_addr_o = 16'h0000;
        bus_wdata_o = 16'h0000;
        bus_wr_o = 1'b0;
        bus_rd_o = 1'b0;
    end

    // Idle address and data are inverted so that stale values never look valid.
    task automatic wr(input sevg_pkg::sevg_addr_t a, input sevg_pkg::sevg_word_t d);
        @(posedge core_clk_i);
        bus_addr_o <= a;
        bus_wdata_o <= d;
        bus_wr_o <= 1'b1;
        @(posedge core_clk_i);
        bus_addr_o <= ~a;
        bus_wdata_o <= ~d;
        bus_wr_o <= 1'b0;
    endtask

    // Read data stand for one cycle only, so they are taken right after that edge.
    task automatic rd(input sevg_pkg::sevg_addr_t a, output sevg_pkg::sevg_word_t d);
        @(posedge core_clk_i);
        bus_addr_o <= a;
        bus_rd_o <= 1'b1;
        @(posedge core_clk_i);
        bus_addr_o <= ~a;
        bus_rd_o <= 1'b0;
        #1;
        d = bus_rdata_i;
    endtask
endmodule

// file: bench/tb_system_event_vector_generator.sv
`timescale 1ns/1ns
`include "sevg_consts.svh"

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_system_event_vector_generator;
    logic                 core_clk_i, reset_n_i, bus_wr_i, bus_rd_i, dbg_wr_i, dbg_take_i;
    logic                 dbg_in_full_o, dbg_out_full_o, sys_nmi_req_o, user_nmi_req_o;
    logic                 brownout_reset_o, por_reset_o, clear_reset_o;
    sevg_pkg::sevg_addr_t bus_addr_i;
    sevg_pkg::sevg_word_t bus_wdata_i, bus_rdata_o, dbg_wdata_i, dbg_rdata_o, d, dw, aw;
    logic [23:0]          rst_cause_set_i;
    logic [15:0]          sys_cause_set_i, user_cause_set_i;
    logic [23:0]          m [3];
    logic [23:0]          en [3];
    logic [23:0]          valid [3];
    sevg_pkg::sevg_addr_t vec_a [3];
    sevg_pkg::sevg_addr_t en_a [3];
    int                   seed = 32'h792d;
    int                   num_errors = 0;
    int                   tests_run = 0;

    sevg_event_vectors u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
        .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .rst_cause_set_i(rst_cause_set_i),
        .sys_cause_set_i(sys_cause_set_i), .user_cause_set_i(user_cause_set_i),
        .dbg_wr_i(dbg_wr_i), .dbg_wdata_i(dbg_wdata_i), .dbg_take_i(dbg_take_i),
        .dbg_rdata_o(dbg_rdata_o), .dbg_in_full_o(dbg_in_full_o),
        .dbg_out_full_o(dbg_out_full_o), .sys_nmi_req_o(sys_nmi_req_o),
        .user_nmi_req_o(user_nmi_req_o), .brownout_reset_o(brownout_reset_o),
        .por_reset_o(por_reset_o), .clear_reset_o(clear_reset_o));

    sevg_core_model u_core (.core_clk_i(core_clk_i), .bus_addr_o(bus_addr_i),
        .bus_wdata_o(bus_wdata_i), .bus_wr_o(bus_wr_i), .bus_rd_o(bus_rd_i),
        .bus_rdata_i(bus_rdata_o));

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    function automatic logic [15:0] top_code(input logic [23:0] f);
        for (int i = 0; i < 24; i++) begin
            if (f[i]) return 16'(2 * i);
        end
        return 16'h0000;
    endfunction

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic clear_model;
        for (int k = 0; k < 3; k++) begin
            m[k] = 24'h000000;
            en[k] = 24'hffffff;
        end
    endtask

    // Reads a vector until no enabled cause is left in the model; each read retires one cause only.
    task automatic drain(input int k);
        logic [15:0] e;
        for (int n = 0; n < 25; n++) begin
            e = top_code(m[k] & valid[k] & en[k]);
            u_core.rd(vec_a[k], d);
            `CHK(d, e)
            if (e == 16'h0000) break;
            m[k][e[5:1]] = 1'b0;
        end
    endtask

    task automatic hit(input int k, input logic [23:0] v);
        logic [23:0] s;
        logic [2:0]  x;
        s = v & valid[k] & ((k == 1) ? 24'hfff3ff : 24'hffffff);
        @(posedge core_clk_i);
        rst_cause_set_i <= (k == 0) ? v : 24'h000000;
        sys_cause_set_i <= (k == 1) ? v[15:0] : 16'h0000;
        user_cause_set_i <= (k == 2) ? v[15:0] : 16'h0000;
        @(posedge core_clk_i);
        rst_cause_set_i <= 24'h000000;
        sys_cause_set_i <= 16'h0000;
        user_cause_set_i <= 16'h0000;
        #1;
        m[k] = m[k] | s;
        if (k == 0) begin
            x[2] = |(s & `SEVG_RST_BROWN_MASK);
            x[1] = !x[2] && |(s & `SEVG_RST_POR_MASK);
            x[0] = !x[2] && !x[1] && |(s & `SEVG_RST_CLEAR_MASK);
            `CHK({brownout_reset_o, por_reset_o, clear_reset_o}, x)
        end else begin
            `CHK((k == 1) ? sys_nmi_req_o : user_nmi_req_o, |(m[k] & valid[k] & en[k]))
        end
    endtask

    task automatic dbg_pulse(input logic w, input sevg_pkg::sevg_word_t dv);
        @(posedge core_clk_i);
        dbg_wr_i <= w;
        dbg_take_i <= !w;
        dbg_wdata_i <= dv;
        @(posedge core_clk_i);
        dbg_wr_i <= 1'b0;
        dbg_take_i <= 1'b0;
        dbg_wdata_i <= ~dv;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask

    initial begin
        repeat (60000) @(posedge core_clk_i);
        num_errors++;
        end_sim();
    end

    initial begin
        valid = '{`SEVG_RST_VALID, {8'h00, `SEVG_SYS_VALID}, {8'h00, `SEVG_USER_VALID}};
        vec_a = '{`SEVG_ADDR_RST_VEC, `SEVG_ADDR_SYS_VEC, `SEVG_ADDR_USER_VEC};
        en_a = '{16'h0000, `SEVG_ADDR_SYS_EN, `SEVG_ADDR_USER_EN};
        {reset_n_i, dbg_wr_i, dbg_take_i, dbg_wdata_i} = 19'h00000;
        {rst_cause_set_i, sys_cause_set_i, user_cause_set_i} = 56'h0;
        clear_model();
        repeat (4) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        for (int k = 0; k < 3; k++) drain(k);
        for (int i = 0; i < 24; i++) begin
            hit(0, 24'h000001 << i);
            drain(0);
        end
        repeat (16) begin
            hit(0, 24'($random(seed)));
            drain(0);
        end
        for (int k = 1; k < 3; k++) begin
            repeat (16) begin
                d = 16'($random(seed));
                u_core.wr(en_a[k], d);
                en[k] = {8'hff, d};
                u_core.rd(en_a[k], dw);
                `CHK(dw, d)
                hit(k, 24'($random(seed)));
                drain(k);
            end
            u_core.wr(en_a[k], 16'h0000);
            en[k] = 24'hff0000;
            hit(k, 24'h00ffff);
            u_core.wr(en_a[k], 16'hffff);
            en[k] = 24'hffffff;
            drain(k);
        end
        hit(2, 24'h000004);
        drain(2);
        dw = 16'($random(seed));
        aw = 16'($random(seed));
        dbg_pulse(1'b0, 16'h0000);
        dbg_pulse(1'b1, dw);
        `CHK(dbg_in_full_o, 1'b1)
        m[1][10] = 1'b1;
        u_core.rd(`SEVG_ADDR_MBOX_CTL, d);
        `CHK(d, 16'h0001)
        u_core.rd(`SEVG_ADDR_MBOX_IN, d);
        `CHK(d, dw)
        u_core.wr(`SEVG_ADDR_MBOX_OUT, aw);
        #1;
        `CHK({dbg_in_full_o, dbg_out_full_o, dbg_rdata_o}, {2'b01, aw})
        u_core.rd(`SEVG_ADDR_MBOX_OUT, d);
        `CHK(d, aw)
        dbg_pulse(1'b0, 16'h0000);
        `CHK(dbg_out_full_o, 1'b0)
        m[1][11] = 1'b1;
        drain(1);
        hit(1, 24'h001000);
        fork
            u_core.rd(`SEVG_ADDR_SYS_VEC, d);
            hit(1, 24'h001000);
        join
        `CHK(d, 16'h0018)
        drain(1);
        u_core.wr(`SEVG_ADDR_RST_VEC, 16'hffff);
        u_core.rd(16'h01a0, d);
        `CHK(d, 16'h0000)
        hit(0, 24'h000800);
        @(posedge core_clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        clear_model();
        drain(0);
        end_sim();
    end
endmodule
